// ---- verif/dmas_meas_model.sv ----
`timescale 1ns/10ps
// far side of the measurement port: one run per start, answered after a delay
module dmas_meas_model (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       meas_start,
   input  wire logic [7:0] delay,      // cycles per run, 1 is prompt
   input  wire logic       fail_en,    // answer with a failure instead
   output logic            meas_done,
   output logic            meas_fail
);
   logic [7:0] cnt_q; // cycles left in the current run

   // one run at a time, each answered by a single pulse
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q     <= 8'h00;
         meas_done <= 1'b0;
         meas_fail <= 1'b0;
      end else begin
         meas_done <= 1'b0;
         meas_fail <= 1'b0;
         if (meas_start) begin
            cnt_q <= delay;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            // end of run: report outcome
            if (cnt_q == 8'h01) begin
               meas_done <= !fail_en;
               meas_fail <= fail_en;
            end
         end
      end
   end
endmodule // dmas_meas_model

// ---- verif/dmas_top_asserts.sv ----
`timescale 1ns/10ps
// watches the top ports of the mode and setup block
module dmas_top_asserts (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        reg_wr,
   input  wire logic        din4_pin,
   input  wire logic        meas_done,
   input  wire logic        meas_start,
   input  wire logic [2:0]  meas_item,
   input  wire logic        store_req,
   input  wire logic [7:0]  store_cat,
   input  wire logic        op_enabled,
   input  wire logic [1:0]  drive_mode,
   input  wire logic        closed_loop,
   input  wire logic        joystick,
   input  wire logic [15:0] speed_rpm,
   input  wire logic [15:0] offset_mv
);
   logic [3:0] quiet_q; // cycles since the last register write

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // saturating count of cycles without a write
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) quiet_q <= 4'h0;
      else if (reg_wr) quiet_q <= 4'h0;
      else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
   end

   meas_pulse_a: assert property (
      meas_start |=> !meas_start && $stable(meas_item))
      else $error("measurement start not a single pulse");
   meas_cause_a: assert property (
      meas_start |-> $past(meas_done, 2) || $past(meas_done, 3)
                     || $past(reg_wr, 3) || $past(reg_wr, 4))
      else $error("measurement start without cause");
   store_first_a: assert property (
      store_req && store_cat == 8'h05 |-> $past(meas_done, 2) || $past(meas_done, 3))
      else $error("drive store not after last run");
   store_pair_a: assert property (
      store_req && store_cat == 8'h05 |=> store_req && store_cat == 8'h06)
      else $error("tuning store missing after drive store");
   test_speed_a: assert property (
      drive_mode == 2'h2 |-> speed_rpm == 16'h001e && offset_mv == 16'h0000)
      else $error("test run speed wrong");
   analog_set_a: assert property (
      drive_mode == 2'h3 |-> offset_mv == (joystick ? 16'h1388 : 16'h0000)
                 && (speed_rpm == 16'h03e8 || speed_rpm == 16'h0064))
      else $error("analog speed settings wrong");
   idle_drive_a: assert property (
      drive_mode == 2'h0 |-> speed_rpm == 16'h0 && offset_mv == 16'h0 && !closed_loop)
      else $error("drive outputs set without special mode");
   mode_hold_a: assert property (
      $changed(drive_mode) |-> quiet_q < 4'hc)
      else $error("drive mode changed without restart");
   enable_only_a: assert property (
      // a restart trigger write holds the power state off for a few cycles
      (drive_mode != 2'h0 && $stable(din4_pin))[*5] ##0 quiet_q > 4'h6
      |-> op_enabled == din4_pin)
      else $error("power state not following enable input");
endmodule // dmas_top_asserts

bind dmas_top dmas_top_asserts dmas_top_asserts_i (
   .sys_clk(sys_clk), .reset_n(reset_n), .reg_wr(reg_wr), .din4_pin(din4_pin),
   .meas_done(meas_done), .meas_start(meas_start), .meas_item(meas_item),
   .store_req(store_req), .store_cat(store_cat), .op_enabled(op_enabled),
   .drive_mode(drive_mode), .closed_loop(closed_loop), .joystick(joystick),
   .speed_rpm(speed_rpm), .offset_mv(offset_mv));

// ---- verif/dmas_top_tb.sv ----
`timescale 1ns/10ps
`include "dmas_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module dmas_top_tb;
   logic        sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, din4_pin = 0;
   logic        enc_index_pin = 0, fail_en = 0, meas_done, meas_fail, meas_start;
   logic        store_req, prog_run, op_enabled, closed_loop, test_ccw, joystick, irq;
   logic [7:0]  reg_addr = 0, delay = 1, store_cat;
   logic [31:0] reg_wdata = 0, reg_rdata, rd_val;
   logic [3:0]  switch_pin = 0;
   logic [2:0]  sense_pin = 0, meas_item;
   logic [1:0]  drive_mode;
   logic [15:0] speed_rpm, offset_mv;
   logic [6:0]  seen;  // items started in the current setup
   int          n_starts, n_store, n_errors, n_tests, cyc, k;
   // {switches 4..1, mode, ccw, joystick, rpm, offset mv}
   logic [39:0] rows [8] = '{
      {4'h0, 2'h1, 2'b00, 16'h0000, 16'h0000}, {4'hc, 2'h1, 2'b00, 16'h0000, 16'h0000},
      {4'h2, 2'h2, 2'b00, 16'h001e, 16'h0000}, {4'he, 2'h2, 2'b10, 16'h001e, 16'h0000},
      {4'h1, 2'h3, 2'b00, 16'h03e8, 16'h0000}, {4'hd, 2'h3, 2'b00, 16'h0064, 16'h0000},
      {4'h3, 2'h3, 2'b01, 16'h03e8, 16'h1388}, {4'hf, 2'h3, 2'b01, 16'h0064, 16'h1388}};

   dmas_top dmas_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .switch_pin(switch_pin), .din4_pin(din4_pin), .enc_index_pin(enc_index_pin),
      .sense_pin(sense_pin), .meas_done(meas_done), .meas_fail(meas_fail),
      .meas_start(meas_start), .meas_item(meas_item), .store_req(store_req),
      .store_cat(store_cat), .prog_run(prog_run), .op_enabled(op_enabled),
      .drive_mode(drive_mode), .closed_loop(closed_loop), .test_ccw(test_ccw),
      .joystick(joystick), .speed_rpm(speed_rpm), .offset_mv(offset_mv), .irq(irq));
   dmas_meas_model dmas_meas_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
      .meas_start(meas_start), .delay(delay), .fail_en(fail_en),
      .meas_done(meas_done), .meas_fail(meas_fail));

   // 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // run log and hang guard
   always @(posedge sys_clk) begin
      if (meas_start) begin
         seen[meas_item] = 1'b1;
         n_starts++;
      end
      if (store_req) n_store++;
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic final_report;
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // one-cycle write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   // restart through the trigger, then let the startup walk finish
   task automatic restart;
      wr(`DMAS_OFF_TRIG, 32'h1);
      repeat (12) @(posedge sys_clk);
      #1;
   endtask

   // start one setup and poll its interrupt status
   task automatic run_setup;
      int i;
      wr(`DMAS_OFF_IRQ_STAT, 32'h7);
      seen = 7'h00;
      wr(`DMAS_OFF_CTRLW, 32'h0f);
      wr(`DMAS_OFF_CTRLW, 32'h1f);
      for (i = 0; i < 400; i++) begin
         rd(`DMAS_OFF_IRQ_STAT);
         if (rd_val[1:0] != 2'b00) break;
      end
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 `CHK(irq, 1'b0)
      rd(`DMAS_OFF_CFG); `CHK(rd_val, 32'h2)
      rd(8'h3c); `CHK(rd_val, 32'h0)
      din4_pin <= 1'b1;
      // eight of the sixteen switch settings through a restart
      for (k = 0; k < 8; k++) begin
         switch_pin <= rows[k][39:36];
         restart();
         `CHK({drive_mode, closed_loop, test_ccw, joystick, speed_rpm, offset_mv}, {rows[k][35:34], rows[k][39], rows[k][33:0]})
         `CHK(op_enabled, 1'b1)
      end
      rd(`DMAS_OFF_TRIG); `CHK(rd_val[0], 1'b0)
      switch_pin <= 4'h0;
      wr(`DMAS_OFF_CTRLW, 32'h0);
      repeat (10) @(posedge sys_clk);
      #1 `CHK(drive_mode, 2'h3)
      `CHK(op_enabled, 1'b1)
      din4_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 `CHK(op_enabled, 1'b0)
      wr(`DMAS_OFF_CFG, 32'h0); restart();
      `CHK({drive_mode, speed_rpm}, 18'h0)
      wr(`DMAS_OFF_CFG, 32'h1); restart();
      `CHK(prog_run, 1'b1)
      wr(`DMAS_OFF_MODE, 32'hfe);
      wr(`DMAS_OFF_CTRLW, 32'h0f);
      wr(`DMAS_OFF_CTRLW, 32'h1f);
      repeat (20) @(posedge sys_clk);
      `CHK(n_starts, 0)
      wr(`DMAS_OFF_TRIG, 32'h2);
      wr(`DMAS_OFF_CTRLW, 32'h0);
      #1 `CHK(prog_run, 1'b0)
      // full sensor fit, prompt runs, index seen
      wr(`DMAS_OFF_IRQ_MASK, 32'h1);
      sense_pin <= 3'h7;
      enc_index_pin <= 1'b1;
      run_setup();
      `CHK(seen, 7'h7f)
      `CHK(n_store, 2)
      rd(`DMAS_OFF_STATW); `CHK({rd_val[12], rd_val[10]}, 2'b11)
      `CHK(irq, 1'b1)
      wr(`DMAS_OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 `CHK(irq, 1'b0)
      // bare motor, slow runs, no index
      sense_pin <= 3'h0;
      enc_index_pin <= 1'b0;
      delay <= 8'd20;
      run_setup();
      `CHK(seen, 7'h0f)
      `CHK(n_store, 4)
      rd(`DMAS_OFF_STATW); `CHK({rd_val[12], rd_val[10]}, 2'b10)
      // failing run stores nothing
      fail_en <= 1'b1;
      run_setup();
      `CHK(rd_val[1:0], 2'b10)
      `CHK(n_store, 4)
      final_report();
   end
endmodule // dmas_top_tb

// ---- verilog/dmas_map.svh ----
`ifndef DMAS_MAP_SVH
`define DMAS_MAP_SVH
// register offsets on the plain register port
`define DMAS_ADDR_W          8
`define DMAS_OFF_CFG         8'h00
`define DMAS_OFF_MODE        8'h04
`define DMAS_OFF_CTRLW       8'h08
`define DMAS_OFF_STATW       8'h0c
`define DMAS_OFF_ACTIVE      8'h10
`define DMAS_OFF_IRQ_STAT    8'h14
`define DMAS_OFF_IRQ_MASK    8'h18
`define DMAS_OFF_SETUP       8'h1c
`define DMAS_OFF_TRIG        8'h20
// startup configuration fields and reset values
`define DMAS_CFG_PROG_BIT    0
`define DMAS_CFG_SW_BIT      1
`define DMAS_CFG_RST         2'h2
// trigger register fields
`define DMAS_TRIG_RESTART    0
`define DMAS_TRIG_STOP       1
// operating-mode value selecting auto setup
`define DMAS_MODE_AUTOSETUP  8'hfe
// controlword and statusword bits
`define DMAS_CW_START_BIT    4
`define DMAS_CW_ENABLE       4'hf
`define DMAS_SW_OPEN_BIT     2
`define DMAS_SW_IDX_BIT      10
`define DMAS_SW_DONE_BIT     12
// storage categories used after a good setup
`define DMAS_STORE_DRIVE     8'h05
`define DMAS_STORE_TUNE      8'h06
// speeds and offsets of the special drive modes
`define DMAS_RPM_TEST        16'h001e
`define DMAS_RPM_MAX_HI      16'h03e8
`define DMAS_RPM_MAX_LO      16'h0064
`define DMAS_JOY_OFFSET_MV   16'h1388
// interrupt bits
`define DMAS_IRQ_DONE        0
`define DMAS_IRQ_FAIL        1
`define DMAS_IRQ_RESTART     2
`define DMAS_IRQ_W           3
`endif

// ---- verilog/dmas_pkg.sv ----
package dmas_pkg;
   // startup sequence, gray coded along the path
   typedef enum logic [2:0] {
      ST_RESET  = 3'h0,
      ST_CONFIG = 3'h1,
      ST_SWITCH = 3'h3,
      ST_PROG   = 3'h2,
      ST_RUN    = 3'h6
   } dmas_start_type;
   // auto setup sequence
   typedef enum logic [2:0] {
      AS_IDLE  = 3'h0,
      AS_ISSUE = 3'h1,
      AS_WAIT  = 3'h3,
      AS_STORE = 3'h2,
      AS_DONE  = 3'h6
   } dmas_setup_type;
   // measurement items in run order
   typedef enum logic [2:0] {
      MI_MOTOR = 3'h0,
      MI_RES   = 3'h1,
      MI_IND   = 3'h2,
      MI_FLUX  = 3'h3,
      MI_ENC   = 3'h4,
      MI_ALIGN = 3'h5,
      MI_HALL  = 3'h6
   } dmas_item_type;
   // special drive mode selection
   typedef enum logic [1:0] {
      SM_NONE   = 2'h0,
      SM_CLKDIR = 2'h1,
      SM_TEST   = 2'h2,
      SM_ANALOG = 2'h3
   } dmas_smode_type;
   // drive settings latched at restart
   typedef struct packed {
      dmas_smode_type smode;
      logic           closed_loop;
      logic           test_ccw;
      logic           joystick;
      logic [15:0]    max_rpm;
   } dmas_drive_type;
   // sensor fit of the motor
   typedef struct packed {
      logic enc;
      logic enc_index;
      logic hall;
   } dmas_sense_type;
endpackage

// ---- verilog/dmas_sync2.sv ----
`timescale 1ns/10ps
// two-flop synchroniser for slow pin levels
module dmas_sync2 #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q; // first stage, read only by second

   // two stages, nothing else looks at meta_q
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // dmas_sync2

// ---- verilog/dmas_top.sv ----
`timescale 1ns/10ps
`include "dmas_map.svh"
// Behaviour
// - startup config bit starts stored user program
// - trigger restarts device, removed on restart
// - controlword bit 4 starts sequential measurement runs
// - statusword bit 12 set when setup done
// - statusword bit 10 reports index found
// - base items always, encoder items only when encoder and index both fitted, hall when fitted
// - good setup stores drive and tuning categories
// - special mode: power state from enable only
// - digital input four is the enable
// - switch evaluation on by default, config disables
// - switch1 off: clock-direction or 30 rpm test
// - switch1 on: analog speed, direction, max speed
// - switch 4 picks open or closed loop
// - config, then switches, then user program
// - switches and config sampled only at restart
module dmas_top #(
   parameter int SW_N = 4 // rear-panel switch count
) (
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire logic [`DMAS_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   input  wire logic [SW_N-1:0]        switch_pin,
   input  wire logic                   din4_pin,
   input  wire logic                   enc_index_pin,
   input  wire logic [2:0]             sense_pin,
   input  wire logic                   meas_done,
   input  wire logic                   meas_fail,
   output logic                        meas_start,
   output logic      [2:0]             meas_item,
   output logic                        store_req,
   output logic      [7:0]             store_cat,
   output logic                        prog_run,
   output logic                        op_enabled,
   output logic      [1:0]             drive_mode,
   output logic                        closed_loop,
   output logic                        test_ccw,
   output logic                        joystick,
   output logic      [15:0]            speed_rpm,
   output logic      [15:0]            offset_mv,
   output logic                        irq
);
   // refuse widths the decoder cannot serve
   if (SW_N != 4) begin : g_chk
      $error("dmas_top needs exactly four switches");
   end

   // synchronised pins
   logic [SW_N-1:0]      sw_s;       // switches
   logic                 din4_s;     // enable input
   logic                 idx_s;      // encoder index
   dmas_pkg::dmas_sense_type sense_s; // sensor fit

   dmas_sync2 #(.W(SW_N + 5)) u_sync (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .async_in ({switch_pin, din4_pin, enc_index_pin, sense_pin}),
      .sync_out ({sw_s, din4_s, idx_s, sense_s})
   );

   // software-visible state
   logic [1:0]  cfg_q;        // startup config as written
   logic [7:0]  mode_q;       // operating-mode selection
   logic [15:0] ctrlw_q;      // controlword
   logic        restart_q;    // restart trigger present
   logic [`DMAS_IRQ_W-1:0] irq_stat_q; // sticky events
   logic [`DMAS_IRQ_W-1:0] irq_mask_q; // event enables
   // latched at restart, sensor fit latched at setup start
   logic [1:0]  cfg_act_q;    // active startup config
   dmas_pkg::dmas_drive_type drv_q; // active drive settings
   dmas_pkg::dmas_sense_type sense_q; // sensors seen at setup
   // sequencers
   dmas_pkg::dmas_start_type st_q;
   dmas_pkg::dmas_setup_type as_q;
   dmas_pkg::dmas_item_type  item_q;
   logic        start_prev_q; // controlword bit 4 last cycle
   logic        done_q;       // setup complete flag
   logic        idx_seen_q;   // index pulse seen in setup
   logic        ok_q;         // setup ended without fault
   logic [1:0]  store_n_q;    // store requests sent
   // event pulses
   logic        ev_done;
   logic        ev_fail;
   logic        ev_restart;

   // decode strobes
   logic wr_cfg, wr_mode, wr_ctrlw, wr_stat, wr_mask, wr_trig;
   assign wr_cfg   = reg_wr && reg_addr == `DMAS_OFF_CFG;
   assign wr_mode  = reg_wr && reg_addr == `DMAS_OFF_MODE;
   assign wr_ctrlw = reg_wr && reg_addr == `DMAS_OFF_CTRLW;
   assign wr_stat  = reg_wr && reg_addr == `DMAS_OFF_IRQ_STAT;
   assign wr_mask  = reg_wr && reg_addr == `DMAS_OFF_IRQ_MASK;
   assign wr_trig  = reg_wr && reg_addr == `DMAS_OFF_TRIG;

   // special mode active after switch decode
   logic special;
   assign special = drv_q.smode != dmas_pkg::SM_NONE;

   // power state: enable pin in special modes, else controlword
   logic op_en_d;
   always_comb begin
      if (special) begin
         op_en_d = din4_s;
      end else begin
         op_en_d = ctrlw_q[3:0] == `DMAS_CW_ENABLE;
      end
   end

   // start request: rising bit 4 in auto setup mode, enabled
   logic start_req;
   assign start_req = ctrlw_q[`DMAS_CW_START_BIT] && !start_prev_q
                      && mode_q == `DMAS_MODE_AUTOSETUP
                      && op_enabled
                      && !prog_run
                      && !special && st_q == dmas_pkg::ST_RUN;

   // next measurement item, skipping absent sensors
   function automatic dmas_pkg::dmas_item_type next_item(
      input dmas_pkg::dmas_item_type cur,
      input dmas_pkg::dmas_sense_type s
   );
      dmas_pkg::dmas_item_type n;
      n = dmas_pkg::MI_MOTOR;
      case (cur)
         dmas_pkg::MI_MOTOR: n = dmas_pkg::MI_RES;
         dmas_pkg::MI_RES:   n = dmas_pkg::MI_IND;
         dmas_pkg::MI_IND:   n = dmas_pkg::MI_FLUX;
         dmas_pkg::MI_FLUX:  n = (s.enc && s.enc_index) ? dmas_pkg::MI_ENC :
                                 (s.hall ? dmas_pkg::MI_HALL : dmas_pkg::MI_MOTOR);
         dmas_pkg::MI_ENC:   n = dmas_pkg::MI_ALIGN;
         dmas_pkg::MI_ALIGN: n = s.hall ? dmas_pkg::MI_HALL : dmas_pkg::MI_MOTOR;
         default:            n = dmas_pkg::MI_MOTOR;
      endcase
      return n;
   endfunction

   // software registers: config, mode, controlword
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q   <= `DMAS_CFG_RST;
         mode_q  <= 8'h00;
         ctrlw_q <= 16'h0000;
      end else begin
         if (wr_cfg) begin
            cfg_q <= reg_wdata[1:0];
         end
         if (wr_mode) begin
            mode_q <= reg_wdata[7:0];
         end
         if (wr_ctrlw) begin
            ctrlw_q <= reg_wdata[15:0];
         end
      end
   end

   // restart trigger: placed by software, removed on restart
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         restart_q <= 1'b0;
      end else if (wr_trig && reg_wdata[`DMAS_TRIG_RESTART]) begin
         restart_q <= 1'b1;
      end else if (st_q == dmas_pkg::ST_CONFIG) begin
         restart_q <= 1'b0;
      end
   end

   // startup sequencer: config, switches, program, run
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= dmas_pkg::ST_RESET;
      end else begin
         case (st_q)
            dmas_pkg::ST_RESET:  st_q <= dmas_pkg::ST_CONFIG;
            dmas_pkg::ST_CONFIG: st_q <= dmas_pkg::ST_SWITCH;
            dmas_pkg::ST_SWITCH: st_q <= dmas_pkg::ST_PROG;
            dmas_pkg::ST_PROG:   st_q <= dmas_pkg::ST_RUN;
            dmas_pkg::ST_RUN: begin
               if (restart_q) begin
                  st_q <= dmas_pkg::ST_RESET;
               end
            end
            default: st_q <= dmas_pkg::ST_RESET;
         endcase
      end
   end

   // latch startup config only while restarting
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_act_q <= `DMAS_CFG_RST;
      end else if (st_q == dmas_pkg::ST_CONFIG) begin
         cfg_act_q <= cfg_q;
      end
   end

   // decode switches once per restart
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         drv_q <= '0;
      end else if (st_q == dmas_pkg::ST_SWITCH) begin
         if (!cfg_act_q[`DMAS_CFG_SW_BIT]) begin
            drv_q <= '0;
         end else begin
            drv_q.closed_loop <= sw_s[3];
            drv_q.test_ccw    <= !sw_s[0] && sw_s[1] && sw_s[2];
            drv_q.joystick    <= sw_s[0] && sw_s[1];
            if (sw_s[0]) begin
               drv_q.smode   <= dmas_pkg::SM_ANALOG;
               drv_q.max_rpm <= sw_s[2] ? `DMAS_RPM_MAX_LO : `DMAS_RPM_MAX_HI;
            end else if (sw_s[1]) begin
               drv_q.smode   <= dmas_pkg::SM_TEST;
               drv_q.max_rpm <= `DMAS_RPM_TEST;
            end else begin
               drv_q.smode   <= dmas_pkg::SM_CLKDIR;
               drv_q.max_rpm <= 16'h0000;
            end
         end
      end
   end

   // user program: started last in startup, stoppable by host
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_run <= 1'b0;
      end else if (st_q == dmas_pkg::ST_CONFIG) begin
         prog_run <= 1'b0;
      end else if (st_q == dmas_pkg::ST_PROG) begin
         prog_run <= cfg_act_q[`DMAS_CFG_PROG_BIT];
      end else if (wr_trig && reg_wdata[`DMAS_TRIG_STOP]) begin
         prog_run <= 1'b0;
      end
   end

   // drive outputs follow the latched settings
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_enabled  <= 1'b0;
         drive_mode  <= 2'h0;
         closed_loop <= 1'b0;
         test_ccw    <= 1'b0;
         joystick    <= 1'b0;
         speed_rpm   <= 16'h0000;
         offset_mv   <= 16'h0000;
      end else begin
         op_enabled  <= (st_q == dmas_pkg::ST_RUN) && op_en_d;
         drive_mode  <= drv_q.smode;
         closed_loop <= drv_q.closed_loop;
         test_ccw    <= drv_q.test_ccw;
         joystick    <= drv_q.joystick;
         speed_rpm   <= drv_q.max_rpm;
         offset_mv   <= drv_q.joystick ? `DMAS_JOY_OFFSET_MV : 16'h0000;
      end
   end

   // auto setup sequencer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         as_q       <= dmas_pkg::AS_IDLE;
         item_q     <= dmas_pkg::MI_MOTOR;
         sense_q    <= '0;
         ok_q       <= 1'b0;
         store_n_q  <= 2'h0;
      end else begin
         case (as_q)
            dmas_pkg::AS_IDLE, dmas_pkg::AS_DONE: begin
               if (start_req) begin
                  as_q    <= dmas_pkg::AS_ISSUE;
                  item_q  <= dmas_pkg::MI_MOTOR;
                  sense_q <= sense_s;
                  ok_q    <= 1'b0;
               end
            end
            dmas_pkg::AS_ISSUE: as_q <= dmas_pkg::AS_WAIT;
            dmas_pkg::AS_WAIT: begin
               if (meas_fail) begin
                  as_q <= dmas_pkg::AS_DONE;                  // no store on fault
               end else if (meas_done) begin
                  if (next_item(item_q, sense_q) == dmas_pkg::MI_MOTOR) begin
                     as_q      <= dmas_pkg::AS_STORE;
                     ok_q      <= 1'b1;
                     store_n_q <= 2'h0;
                  end else begin
                     item_q <= next_item(item_q, sense_q);
                     as_q   <= dmas_pkg::AS_ISSUE;
                  end
               end
            end
            dmas_pkg::AS_STORE: begin
               store_n_q <= store_n_q + 2'h1;
               if (store_n_q == 2'h1) begin
                  as_q <= dmas_pkg::AS_DONE;
               end
            end
            default: as_q <= dmas_pkg::AS_IDLE;
         endcase
      end
   end

   // measurement and storage strobes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meas_start <= 1'b0;
         meas_item  <= 3'h0;
         store_req  <= 1'b0;
         store_cat  <= 8'h00;
      end else begin
         meas_start <= as_q == dmas_pkg::AS_ISSUE;
         meas_item  <= item_q;
         store_req  <= as_q == dmas_pkg::AS_STORE;
         store_cat  <= (store_n_q == 2'h0) ? `DMAS_STORE_DRIVE : `DMAS_STORE_TUNE;
      end
   end

   // done and index flags for the statusword
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_q       <= 1'b0;
         idx_seen_q   <= 1'b0;
         start_prev_q <= 1'b0;
      end else begin
         start_prev_q <= ctrlw_q[`DMAS_CW_START_BIT];
         if (start_req) begin
            done_q     <= 1'b0;
            idx_seen_q <= 1'b0;
         end else begin
            if (as_q != dmas_pkg::AS_DONE && as_q != dmas_pkg::AS_IDLE
                && idx_s) begin
               idx_seen_q <= 1'b1;
            end
            if (as_q == dmas_pkg::AS_STORE && store_n_q == 2'h1) begin
               done_q <= 1'b1;
            end else if (as_q == dmas_pkg::AS_WAIT && meas_fail) begin
               done_q <= 1'b1;
            end
         end
      end
   end

   // event pulses
   assign ev_done    = as_q == dmas_pkg::AS_STORE && store_n_q == 2'h1;
   assign ev_fail    = as_q == dmas_pkg::AS_WAIT && meas_fail;
   assign ev_restart = st_q == dmas_pkg::ST_PROG;

   // sticky events, write one to clear, set wins
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_wdata[`DMAS_IRQ_W-1:0] : '0))
                       | {ev_restart, ev_fail, ev_done};
         if (wr_mask) begin
            irq_mask_q <= reg_wdata[`DMAS_IRQ_W-1:0];
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read mux, data valid in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `DMAS_OFF_CFG:      reg_rdata <= {30'h0, cfg_q};
            `DMAS_OFF_MODE:     reg_rdata <= {24'h0, mode_q};
            `DMAS_OFF_CTRLW:    reg_rdata <= {16'h0, ctrlw_q};
            `DMAS_OFF_STATW:    reg_rdata <= {19'h0, done_q, 1'b0, idx_seen_q,
                                              7'h0, op_enabled, 2'h0};
            `DMAS_OFF_ACTIVE:   reg_rdata <= {drv_q.max_rpm, 8'h0, prog_run,
                                              cfg_act_q[1], drv_q.joystick,
                                              drv_q.test_ccw, drv_q.closed_loop,
                                              1'b0, drv_q.smode};
            `DMAS_OFF_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_q};
            `DMAS_OFF_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_q};
            `DMAS_OFF_SETUP:    reg_rdata <= {22'h0, ok_q, sense_q, as_q, item_q};
            `DMAS_OFF_TRIG:     reg_rdata <= {31'h0, restart_q};
            default:            reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule // dmas_top
